/* File: verilog/iepx_top.v */
// interrupt enable, priority and external interrupt 2/3 configuration block
//
// What this block does
// - global enable zero blocks every source
// - main enable holds six individual enables
// - ext1 polarity bit selects high or rising
// - ext0 polarity bit selects high or rising
// - break flag set by event, blocks pwm
// - modulator switch events set sticky flags
// - ext3 polarity bit selects high or rising
// - ext flags hardware set, service clears
// - type bit picks edge or level
// - sleeping ext trigger sets flag, wakes
// - disabled ext source never wakes cpu
// - ext2 polarity bit selects high or rising
// - control register holds ext3, ext2 enables
// - priority group low and high bits
// - extended enable register holds eight enables
// - system flag is OR of gated flags
// - keypad match requests when enabled
// - conversion done requests when enabled
// - spi done requests when enabled
// - two priority bits form four levels
// - sample flags, poll next cycle, call
// - higher level served first, preempts only lower levels
`timescale 1ns/1ps
`default_nettype none
`include "iepx_regs.vh"

module iepx_top (
  input  wire       ref_clk,
  input  wire       rstn,
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  input  wire       ext0_flag,
  input  wire       timer0_flag,
  input  wire       ext1_flag,
  input  wire       timer1_flag,
  input  wire       serial0_flag,
  input  wire       timer2_flag,
  input  wire       spi_transfer_done_flag,
  input  wire       conversion_done_flag,
  input  wire       counter_array_flag,
  input  wire       serial1_flag,
  input  wire       keypad_match_flag,
  input  wire       two_wire_flag,
  input  wire       comparator0_flag,
  input  wire [5:0] sys_flags,
  input  wire [6:0] system_flag_sub_enables,
  input  wire [7:0] ext_prio_high,
  input  wire [7:0] ext_prio_low,
  input  wire       ext_irq2_input,
  input  wire       ext_irq3_input,
  input  wire       pwm_break_event,
  input  wire       mod0_switch_event,
  input  wire       mod1_switch_event,
  input  wire       mod0_switch_src_en,
  input  wire       mod1_switch_src_en,
  input  wire       cpu_sleeping,
  input  wire       cpu_poll_ok,
  input  wire       irq_ack,
  input  wire       irq_return,
  output reg        irq_req,
  output reg  [4:0] irq_vector,
  output reg  [1:0] irq_level,
  output reg        cpu_wake,
  output reg        pwm_break_flag,
  output reg        ext0_high_polarity,
  output reg        ext1_high_polarity
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0] aux_control_zero;
  reg [7:0] interrupt_enable_main;
  reg [7:0] interrupt_enable_ext_one;
  reg [7:0] external_irq_control;
  reg [7:0] priority_group_zero_low;
  reg [7:0] priority_group_zero_high;
  reg [15:0] pend_sample;
  reg [3:0]  in_progress;
  reg        sfr_wr_hold;
  wire [1:0] trig;
  wire       wr_aux;
  wire       wr_ie;
  wire       wr_eie;
  wire       wr_xc;
  wire       wr_plo;
  wire       wr_phi;
  wire       svc_ext2;
  wire       svc_ext3;
  wire       global_irq_enable;
  wire       sys_flag_irq;
  wire [15:0] src_flag;
  wire [15:0] src_en;
  wire [15:0] pend;
  wire [15:0] prio_hi;
  wire [15:0] prio_lo;

  assign wr_aux = sfr_wr && (sfr_addr == `IEPX_ADDR_AUX0);
  assign wr_ie  = sfr_wr && (sfr_addr == `IEPX_ADDR_IE_MAIN);
  assign wr_eie = sfr_wr && (sfr_addr == `IEPX_ADDR_IE_EXT1);
  assign wr_xc  = sfr_wr && (sfr_addr == `IEPX_ADDR_XCTRL);
  assign wr_plo = sfr_wr && (sfr_addr == `IEPX_ADDR_PRIO_LO);
  assign wr_phi = sfr_wr && (sfr_addr == `IEPX_ADDR_PRIO_HI);
  assign svc_ext2 = irq_ack && irq_req && (irq_vector == `IEPX_SRC_EXT2);
  assign svc_ext3 = irq_ack && irq_req && (irq_vector == `IEPX_SRC_EXT3);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // combine high and low bit into a level, 3 highest
  function [1:0] level_of;
    input hi;
    input lo;
    begin
      level_of = {hi, lo};
    end
  endfunction
  // highest level currently in service, valid flag in bit 2
  function [2:0] top_in_service;
    input [3:0] act;
    begin
      top_in_service = act[3] ? 3'b111 :
                       act[2] ? 3'b110 :
                       act[1] ? 3'b101 :
                       act[0] ? 3'b100 : 3'b000;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // external interrupt 2 and 3 trigger detection

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ext
      iepx_ext_trig u_trig (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .pin      (gi == 0 ? ext_irq2_input : ext_irq3_input),
        .high_pol (gi == 0 ? external_irq_control[`IEPX_XC_X2H]
                           : external_irq_control[`IEPX_XC_X3H]),
        .edge_sel (gi == 0 ? external_irq_control[`IEPX_XC_ED2]
                           : external_irq_control[`IEPX_XC_ED3]),
        .trig     (trig[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register writes and flag updates

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      aux_control_zero         <= `IEPX_RST_AUX0;
      interrupt_enable_main    <= `IEPX_RST_IE_MAIN;
      interrupt_enable_ext_one <= `IEPX_RST_IE_EXT1;
      external_irq_control     <= `IEPX_RST_XCTRL;
      priority_group_zero_low  <= `IEPX_RST_PRIO;
      priority_group_zero_high <= `IEPX_RST_PRIO;
    end else begin
      if (wr_aux) begin
        aux_control_zero <= sfr_wdata;
      end
      // break event sets, wins over clear
      if (pwm_break_event) begin
        aux_control_zero[`IEPX_AUX_BRK] <= 1'b1;
      end
      if (mod1_switch_event && mod1_switch_src_en) begin
        aux_control_zero[`IEPX_AUX_BM1] <= 1'b1;
      end
      if (mod0_switch_event && mod0_switch_src_en) begin
        aux_control_zero[`IEPX_AUX_BM0] <= 1'b1;
      end
      if (wr_ie) begin
        interrupt_enable_main <= sfr_wdata & 8'hbf;
      end
      if (wr_eie) begin
        interrupt_enable_ext_one <= sfr_wdata;
      end
      if (wr_plo) begin
        priority_group_zero_low <= sfr_wdata;
      end
      if (wr_phi) begin
        priority_group_zero_high <= sfr_wdata;
      end
      if (wr_xc) begin
        external_irq_control <= sfr_wdata;
      end
      if (svc_ext2 && !wr_xc) begin
        external_irq_control[`IEPX_XC_FL2] <= 1'b0;
      end
      if (svc_ext3 && !wr_xc) begin
        external_irq_control[`IEPX_XC_FL3] <= 1'b0;
      end
      // trigger sets flag also when asleep
      if (trig[0]) begin
        external_irq_control[`IEPX_XC_FL2] <= 1'b1;
      end
      if (trig[1]) begin
        external_irq_control[`IEPX_XC_FL3] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source flags and enables

  assign global_irq_enable = interrupt_enable_main[`IEPX_IE_GLOBAL];
  assign sys_flag_irq = |({sys_flags[5],
                           aux_control_zero[`IEPX_AUX_BM1] | aux_control_zero[`IEPX_AUX_BM0],
                           sys_flags[4:0]} & system_flag_sub_enables);

  assign src_flag = {comparator0_flag, two_wire_flag, keypad_match_flag, serial1_flag,
                     sys_flag_irq, counter_array_flag, conversion_done_flag,
                     spi_transfer_done_flag,
                     external_irq_control[`IEPX_XC_FL3], external_irq_control[`IEPX_XC_FL2],
                     timer2_flag, serial0_flag, timer1_flag, ext1_flag, timer0_flag, ext0_flag};

  // main enables, ext2/3 enables, extended enables
  assign src_en = {interrupt_enable_ext_one,
                   external_irq_control[`IEPX_XC_EN3], external_irq_control[`IEPX_XC_EN2],
                   interrupt_enable_main[5:0]};
  // pending needs flag, enable and global
  assign pend = src_flag & src_en & {`IEPX_NUM_SRC{global_irq_enable}};
  // group zero order maps to sources 0..7
  assign prio_hi = {ext_prio_high, priority_group_zero_high[7:6], priority_group_zero_high[5:0]};
  assign prio_lo = {ext_prio_low, priority_group_zero_low[7:6], priority_group_zero_low[5:0]};

  ////////////////////////////////////////////////////////////////////////////
  // arbitration

  reg [1:0] best_lvl;
  reg [4:0] best_idx;
  reg       best_found;
  reg [1:0] cur_lvl;
  reg [2:0] busy;
  integer   k;
  // four levels, highest level wins, lower index on tie
  always @* begin
    best_lvl   = 2'b00;
    best_idx   = 5'd0;
    best_found = 1'b0;
    cur_lvl    = 2'b00;
    busy       = top_in_service(in_progress);
    for (k = `IEPX_NUM_SRC - 1; k >= 0; k = k - 1) begin
      cur_lvl = level_of(prio_hi[k], prio_lo[k]);
      if (pend_sample[k] && (!best_found || cur_lvl >= best_lvl)) begin
        best_lvl   = cur_lvl;
        best_idx   = k[4:0];
        best_found = 1'b1;
      end
    end
    // no preempt by equal or lower level
    if (busy[2] && best_lvl <= busy[1:0]) begin
      best_found = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sampling, polling and service tracking

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend_sample <= 16'h0000;
      sfr_wr_hold <= 1'b0;
      in_progress <= 4'h0;
      irq_req     <= 1'b0;
      irq_vector  <= 5'd0;
      irq_level   <= 2'b00;
    end else begin
      // sample this cycle, poll the next
      pend_sample <= pend;
      sfr_wr_hold <= wr_aux | wr_ie | wr_eie | wr_xc | wr_plo | wr_phi;
      if (irq_ack && irq_req) begin
        irq_req <= 1'b0;
        in_progress[irq_level] <= 1'b1;
      end else if (irq_return) begin
        irq_req <= 1'b0;
        // pop the highest level in service
        in_progress[busy[1:0]] <= 1'b0;
      end else begin
        irq_req    <= best_found && cpu_poll_ok && !sfr_wr_hold && !wr_ie;
        irq_vector <= best_idx;
        irq_level  <= best_lvl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs and read path

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_wake           <= 1'b0;
      pwm_break_flag     <= 1'b0;
      ext0_high_polarity <= 1'b0;
      ext1_high_polarity <= 1'b0;
      sfr_rdata          <= 8'h00;
    end else begin
      // wake on enabled flag, disabled never wakes
      cpu_wake <= cpu_sleeping &&
                  ((external_irq_control[`IEPX_XC_FL2] && external_irq_control[`IEPX_XC_EN2]) ||
                   (external_irq_control[`IEPX_XC_FL3] && external_irq_control[`IEPX_XC_EN3]));
      pwm_break_flag <= aux_control_zero[`IEPX_AUX_BRK] | pwm_break_event;
      ext0_high_polarity <= aux_control_zero[`IEPX_AUX_X0H];
      ext1_high_polarity <= aux_control_zero[`IEPX_AUX_X1H];
      if (sfr_rd) begin
        case (sfr_addr)
          `IEPX_ADDR_AUX0:    sfr_rdata <= aux_control_zero;
          `IEPX_ADDR_IE_MAIN: sfr_rdata <= interrupt_enable_main;
          `IEPX_ADDR_IE_EXT1: sfr_rdata <= interrupt_enable_ext_one;
          `IEPX_ADDR_XCTRL:   sfr_rdata <= external_irq_control;
          `IEPX_ADDR_PRIO_LO: sfr_rdata <= priority_group_zero_low;
          `IEPX_ADDR_PRIO_HI: sfr_rdata <= priority_group_zero_high;
          default:            sfr_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* File: verilog/iepx_regs.vh */
// register offsets, field positions and reset values of the interrupt enable block
`ifndef IEPX_REGS_VH
`define IEPX_REGS_VH

`define IEPX_ADDR_AUX0      8'ha1
`define IEPX_ADDR_IE_MAIN   8'ha8
`define IEPX_ADDR_IE_EXT1   8'had
`define IEPX_ADDR_XCTRL     8'hc0
`define IEPX_ADDR_PRIO_LO   8'hb8
`define IEPX_ADDR_PRIO_HI   8'hb7

`define IEPX_RST_AUX0       8'h00
`define IEPX_RST_IE_MAIN    8'h00
`define IEPX_RST_IE_EXT1    8'h00
`define IEPX_RST_XCTRL      8'h00
`define IEPX_RST_PRIO       8'h00

`define IEPX_IE_GLOBAL      7
`define IEPX_IE_RSVD        6

`define IEPX_AUX_BRK        4
`define IEPX_AUX_BM1        3
`define IEPX_AUX_BM0        2
`define IEPX_AUX_X1H        1
`define IEPX_AUX_X0H        0

`define IEPX_XC_X3H         7
`define IEPX_XC_EN3         6
`define IEPX_XC_FL3         5
`define IEPX_XC_ED3         4
`define IEPX_XC_X2H         3
`define IEPX_XC_EN2         2
`define IEPX_XC_FL2         1
`define IEPX_XC_ED2         0

`define IEPX_EIE_SYSF       3

`define IEPX_SRC_EXT2       5'd6
`define IEPX_SRC_EXT3       5'd7
`define IEPX_NUM_SRC        16
`define IEPX_SUB_MOD        5

`endif

/* File: verilog/iepx_ext_trig.v */
// level or edge trigger detector for one external interrupt input
`timescale 1ns/1ps
`default_nettype none

module iepx_ext_trig (
  input  wire ref_clk,
  input  wire rstn,
  input  wire pin,
  input  wire high_pol,
  input  wire edge_sel,
  output wire trig
);

  wire active;
  reg  prev_active;

  assign active = high_pol ? pin : ~pin;

  // previous level starts active so reset gives no false edge
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prev_active <= 1'b1;
    end else begin
      prev_active <= active;
    end
  end

  assign trig = edge_sel ? (active & ~prev_active) : active;

endmodule

`default_nettype wire

/* File: dv/iepx_checker_assertions.sv */
// port-level concurrent checks for the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module iepx_checker (
  input wire       ref_clk,
  input wire       rstn,
  input wire [7:0] sfr_addr,
  input wire       sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire       sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire       pwm_break_event,
  input wire       cpu_sleeping,
  input wire       irq_ack,
  input wire       irq_req,
  input wire       cpu_wake,
  input wire       pwm_break_flag,
  input wire       ext0_high_polarity,
  input wire       ext1_high_polarity
);
  logic ie_g;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // shadow of the global enable bit
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) ie_g <= 1'b0;
    else if (sfr_wr && sfr_addr == 8'ha8) ie_g <= sfr_wdata[7];
  end
  ////////////////////////////////////////////////////////////////////////
  a_ie_rsvd_zero: assert property (sfr_rd && sfr_addr == 8'ha8 |=> !sfr_rdata[6])
    else $error("main enable bit 6 read as one");
  a_ie_read_back: assert property ((sfr_wr && sfr_addr == 8'ha8) ##1 !sfr_wr ##1
    (sfr_rd && !sfr_wr && sfr_addr == 8'ha8) |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'hbf))
    else $error("main enable read back wrong");
  a_global_gate: assert property ((!ie_g)[*4] |-> !irq_req)
    else $error("request while globally disabled");
  a_ack_drops: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request kept after acknowledge");
  a_break_sets: assert property (pwm_break_event |-> ##[1:2] pwm_break_flag)
    else $error("break event did not set flag");
  a_break_sticky: assert property ((pwm_break_flag && !sfr_wr)[*2] |=> pwm_break_flag)
    else $error("break flag cleared without write");
  a_wake_sleep: assert property (!cpu_sleeping |=> !cpu_wake)
    else $error("wake while cpu awake");
  a_pol_copy: assert property ((sfr_wr && sfr_addr == 8'ha1) ##1 (!sfr_wr)[*2]
    |-> {ext1_high_polarity, ext0_high_polarity} == $past(sfr_wdata[1:0], 2))
    else $error("polarity outputs wrong");
  c_serviced: cover property (irq_req && irq_ack);
  c_woken: cover property (cpu_wake);
  c_break: cover property (pwm_break_flag && sfr_rd);
endmodule
bind iepx_top iepx_checker u_chk (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .pwm_break_event(pwm_break_event), .cpu_sleeping(cpu_sleeping), .irq_ack(irq_ack),
  .irq_req(irq_req), .cpu_wake(cpu_wake), .pwm_break_flag(pwm_break_flag),
  .ext0_high_polarity(ext0_high_polarity), .ext1_high_polarity(ext1_high_polarity));
`default_nettype wire

/* File: dv/iepx_cpu_model.sv */
// cpu side: acknowledges requests after a delay, returns later
`timescale 1ns/1ps
`default_nettype none
module iepx_cpu_model (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       irq_req,
  input  wire logic [1:0] lat,
  output var  logic       irq_ack,
  output var  logic       irq_return
);
  logic [1:0] cnt;
  logic [2:0] rc;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 2'h0;
      rc <= 3'h0;
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      if (irq_req && !irq_ack) begin
        cnt <= (cnt == lat) ? 2'h0 : cnt + 2'h1;
        irq_ack <= (cnt == lat);
      end
      // service routine ends six cycles after entry
      // only an acknowledge the block took starts a routine
      if (irq_ack && irq_req) rc <= 3'h6;
      else if (rc != 3'h0) begin
        rc <= rc - 3'h1;
        irq_return <= (rc == 3'h1);
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/iepx_top_tb.sv */
// self-checking testbench for the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module iepx_top_tb;
  logic ref_clk = 0, rstn = 0, sfr_wr = 0, sfr_rd = 0, x2 = 1, x3 = 1, slp = 0, pok = 1;
  logic bke = 0, m0e = 0, m1e = 0, m0s = 0, m1s = 0, tk, ak;
  logic irq_req, irq_ack, irq_return, wake, brk, p0, p1;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, eph = 0, epl = 0, rdata, d, av;
  logic [15:0] fl = 0;
  logic [5:0] sf = 0;
  logic [1:0] lat = 0, lvl;
  logic [4:0] vec;
  logic [7:0] rq[$], vq[$];
  integer errors = 0, checks_done = 0, i;
  logic [7:0] ads [0:6] = '{8'ha1, 8'ha8, 8'had, 8'hc0, 8'hb8, 8'hb7, 8'h00};
  logic [4:0] tv [0:3] = '{5'd8, 5'd9, 5'd11, 5'd13};
  logic [2:0] teb [0:3] = '{3'd0, 3'd1, 3'd3, 3'd5};
  iepx_top DUT (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(rdata), .ext0_flag(fl[0]),
    .timer0_flag(fl[1]), .ext1_flag(fl[2]), .timer1_flag(fl[3]), .serial0_flag(fl[4]),
    .timer2_flag(fl[5]), .spi_transfer_done_flag(fl[8]), .conversion_done_flag(fl[9]),
    .counter_array_flag(fl[10]), .serial1_flag(fl[12]), .keypad_match_flag(fl[13]),
    .two_wire_flag(fl[14]), .comparator0_flag(fl[15]), .sys_flags(sf),
    .system_flag_sub_enables(7'h01), .ext_prio_high(eph), .ext_prio_low(epl),
    .ext_irq2_input(x2), .ext_irq3_input(x3), .pwm_break_event(bke), .mod0_switch_event(m0e),
    .mod1_switch_event(m1e), .mod0_switch_src_en(m0s), .mod1_switch_src_en(m1s),
    .cpu_sleeping(slp), .cpu_poll_ok(pok), .irq_ack(irq_ack), .irq_return(irq_return),
    .irq_req(irq_req), .irq_vector(vec), .irq_level(lvl), .cpu_wake(wake),
    .pwm_break_flag(brk), .ext0_high_polarity(p0), .ext1_high_polarity(p1));
  iepx_cpu_model u_cpu (.ref_clk(ref_clk), .rstn(rstn), .irq_req(irq_req), .lat(lat),
    .irq_ack(irq_ack), .irq_return(irq_return));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk) begin sfr_addr <= a; sfr_wdata <= v; sfr_wr <= 1'b1; end
    @(posedge ref_clk) sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk) begin sfr_addr <= a; sfr_rd <= 1'b1; rq.push_back(e); end
    @(posedge ref_clk) sfr_rd <= 1'b0;
  endtask
  task automatic wack(input integer v);
    integer n;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (!(irq_req && irq_ack) && n < 200);
    if (n >= 200) begin errors++; $display("[ERR] %0t no service", $time); end
    fl[v] <= 1'b0;
    sf <= 6'h00;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    pok <= ($urandom % 4) != 0;
    lat <= 2'($urandom);
  end
  // result watcher: register reads and serviced vectors
  always @(posedge ref_clk) begin
    tk = sfr_rd;
    ak = irq_req && irq_ack;
    av = {1'b0, lvl, vec};
    #1;
    if (tk) chk(rdata, rq.pop_front());
    if (ak) chk(av, vq.pop_front());
  end
  initial begin
    #200000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
  initial begin
    void'($urandom(32'he04a0b21));
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    for (i = 0; i < 7; i++) rd(ads[i], 8'h00);
    $display("reset values done");
    @(posedge ref_clk) begin eph <= 8'($urandom); epl <= 8'($urandom); end
    for (i = 0; i < 7; i++) begin
      d = 8'($urandom);
      if (i == 1) d = d & 8'hbf;
      if (i == 3) d = d & 8'h55;
      wr(ads[i], d);
      rd(ads[i], (i == 6) ? 8'h00 : d);
      if (i == 0) chk({6'h0, p1, p0}, {6'h0, d[1:0]});
      wr(ads[i], 8'h00);
    end
    $display("register access done");
    wr(8'hb7, 8'h08);
    wr(8'ha8, 8'h0a);
    @(posedge ref_clk) fl <= 16'h000a;
    repeat (8) @(posedge ref_clk);
    chk({7'h0, irq_req}, 8'h00);
    vq.push_back(8'h43);
    vq.push_back(8'h01);
    wr(8'ha8, 8'h8a);
    wack(3);
    wack(1);
    $display("priority service done");
    wr(8'ha8, 8'h00);
    wr(8'hc0, 8'h05);
    @(posedge ref_clk) begin slp <= 1'b1; x2 <= 1'b0; end
    repeat (5) @(posedge ref_clk);
    chk({7'h0, wake}, 8'h01);
    rd(8'hc0, 8'h07);
    wr(8'hc0, 8'h01);
    @(posedge ref_clk) x2 <= 1'b1;
    @(posedge ref_clk) x2 <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk({7'h0, wake}, 8'h00);
    rd(8'hc0, 8'h03);
    @(posedge ref_clk) x2 <= 1'b1;
    wr(8'hc0, 8'h80);
    rd(8'hc0, 8'ha0);
    @(posedge ref_clk) begin x3 <= 1'b0; slp <= 1'b0; end
    wr(8'hc0, 8'h90);
    rd(8'hc0, 8'h90);
    $display("external inputs done");
    wr(8'ha1, 8'h00);
    @(posedge ref_clk) begin m0e <= 1'b1; m1e <= 1'b1; m0s <= 1'b1; end
    @(posedge ref_clk) begin m0e <= 1'b0; m1e <= 1'b0; end
    rd(8'ha1, 8'h04);
    @(posedge ref_clk) bke <= 1'b1;
    @(posedge ref_clk) bke <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({7'h0, brk}, 8'h01);
    rd(8'ha1, 8'h14);
    wr(8'ha1, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk({7'h0, brk}, 8'h00);
    $display("event flags done");
    wr(8'ha8, 8'h80);
    for (i = 0; i < 4; i++) begin
      wr(8'had, 8'h00);
      @(posedge ref_clk) begin if (tv[i] == 5'd11) sf <= 6'h01; else fl[tv[i]] <= 1'b1; end
      repeat (8) @(posedge ref_clk);
      chk({7'h0, irq_req}, 8'h00);
      vq.push_back({1'b0, eph[tv[i] - 5'd8], epl[tv[i] - 5'd8], tv[i]});
      wr(8'had, 8'h01 << teb[i]);
      wack(tv[i]);
    end
    $display("extended sources done");
    vq.push_back(8'h06);
    wr(8'hc0, 8'h06);
    wack(6);
    rd(8'hc0, 8'h24);
    $display("service clear done");
    repeat (10) @(posedge ref_clk);
    wrap_up;
  end
endmodule
`default_nettype wire
